//--- rtl/ulm_top.sv
// UART character format, modem output control and line status with APB access
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ulm_top
  import ulm_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int RTS_LVL = 14
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx,
  output logic o_tx,
  output logic o_dtr_n,
  output logic o_rts_n,
  output logic o_user_output_2_n,
  output logic o_irq,
  output logic o_irq_oe,
  output logic o_loop_ring,
  input wire logic i_tx_halted,
  input wire logic i_sw_flow_on,
  input wire logic [7:0] i_xon_char,
  input wire logic [7:0] i_xoff_char,
  output logic o_xon_resume
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] RTS_HI = (AW + 1)'(RTS_LVL);

  typedef struct packed {
    logic [7:0] line_format_control;
    logic [7:0] modem_output_control;
    logic [7:0] enhanced_feature_control;
    logic [15:0] div;
    logic [1:0] pre;
    logic [15:0] bcnt;
    logic [DEPTH-1:0][7:0] txf;
    logic [AW-1:0] tx_wp;
    logic [AW-1:0] tx_rp;
    logic [AW:0] tx_cnt;
    ulm_tx_state_type tx_st;
    logic [7:0] tx_sh;
    logic tx_par;
    logic [3:0] tx_bit;
    logic [5:0] tx_smp;
    ulm_rx_state_type rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_bit;
    logic [5:0] rx_smp;
    logic rx_pe;
    logic rx_zero;
    logic ir_hit;
    ulm_rx_entry_type [DEPTH-1:0] rxf;
    logic [AW-1:0] rx_wp;
    logic [AW-1:0] rx_rp;
    logic [AW:0] rx_cnt;
    logic [AW:0] err_cnt;
    logic overrun;
    logic tags_hidden;
    logic ls_pend;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_pin;
    logic dtr_n;
    logic rts_n;
    logic op2_n;
    logic irq_oe;
    logic loop_ring;
    logic xon_resume;
  } ulm_state_type;

  ulm_state_type s_r;
  ulm_state_type s_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Keeps only the bits of the programmed word length
  function automatic logic [7:0] mask_data(input logic [7:0] d, input logic [3:0] nb);
    logic [7:0] m;
    m = 8'hFF >> (WL_MAX - nb);
    return d & m;
  endfunction

  // Parity bit to send or expect for a character
  function automatic logic par_bit(input logic [7:0] line_format_control, input logic [7:0] d);
    logic p;
    if (line_format_control[LCR_FORCE]) begin
      p = ~line_format_control[LCR_EVEN];
    end else begin
      p = line_format_control[LCR_EVEN] ? ^d : ~^d;
    end
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic acc;
  logic done;
  logic [3:0] nbits;
  logic [5:0] stop_last;
  logic pre_tick;
  logic tick;
  logic enh;
  logic loop;
  logic ir_on;
  logic ir_pulse;
  logic lin;
  logic ser;
  logic tx_last;
  logic rx_sample;
  logic [7:0] rx_data;
  logic [7:0] rd_val;
  logic bad_addr;
  logic dlab;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic push_tag;
  logic pop_tag;
  logic lsr_rd;
  logic ovr_evt;
  ulm_rx_entry_type head;
  ulm_rx_entry_type ent;

  always_comb begin
    s_nxt = s_r;
    s_nxt.xon_resume = 1'b0;
    acc = i_psel & i_penable;
    done = acc & s_r.pready;
    dlab = s_r.line_format_control[LCR_DLAB];
    enh = s_r.enhanced_feature_control[EFR_ENH];
    loop = s_r.modem_output_control[MCR_LOOP];
    ir_on = s_r.modem_output_control[MCR_IR] & enh;
    nbits = WL_BASE + {2'h0, s_r.line_format_control[1:0]};
    if (!s_r.line_format_control[LCR_STOP]) begin
      stop_last = OVS_LAST;
    end else if (s_r.line_format_control[1:0] == 2'h0) begin
      stop_last = STOP15_LAST;
    end else begin
      stop_last = STOP2_LAST;
    end
    head = s_r.rxf[s_r.rx_rp];
    ent = '0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    push_tag = 1'b0;
    pop_tag = head.pe | head.fe | head.brk;
    lsr_rd = 1'b0;
    ovr_evt = 1'b0;
    rx_sample = 1'b0;

    // Prescaler then baud divisor give the 16x sample tick
    pre_tick = ~s_r.modem_output_control[MCR_PRE] | (s_r.pre == PRE_LAST);
    s_nxt.pre = s_r.modem_output_control[MCR_PRE] ? s_r.pre + 2'h1 : 2'h0;
    tick = 1'b0;
    if (pre_tick) begin
      if (s_r.bcnt == 16'h0000) begin
        s_nxt.bcnt = (s_r.div == 16'h0000) ? 16'h0000 : s_r.div - 16'h0001;
        tick = 1'b1;
      end else begin
        s_nxt.bcnt = s_r.bcnt - 16'h0001;
      end
    end

    // Logical serial level of the transmitter
    case (s_r.tx_st)
      TX_START: ser = 1'b0;
      TX_DATA: ser = s_r.tx_sh[0];
      TX_PAR: ser = s_r.tx_par;
      default: ser = 1'b1;
    endcase
    if (s_r.line_format_control[LCR_BRK]) begin
      ser = 1'b0;
    end

    // Receive line: internal return, infrared decode or plain pin
    ir_pulse = ir_on & (i_rx != s_r.modem_output_control[MCR_OP1]);
    if (loop) begin
      lin = ser;
    end else if (ir_on) begin
      lin = ~(s_r.ir_hit | ir_pulse);
    end else begin
      lin = i_rx;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    tx_last = tick & (s_r.tx_smp == ((s_r.tx_st == TX_STOP) ? stop_last : OVS_LAST));
    if (tick && s_r.tx_st != TX_IDLE) begin
      s_nxt.tx_smp = tx_last ? 6'h00 : s_r.tx_smp + 6'h01;
    end
    case (s_r.tx_st)
      TX_IDLE: begin
        if (s_r.tx_cnt != '0) begin
          tx_pop = 1'b1;
          s_nxt.tx_sh = mask_data(s_r.txf[s_r.tx_rp], nbits);
          s_nxt.tx_par = par_bit(s_r.line_format_control, mask_data(s_r.txf[s_r.tx_rp], nbits));
          s_nxt.tx_st = TX_START;
          s_nxt.tx_smp = 6'h00;
        end
      end
      TX_START: begin
        if (tx_last) begin
          s_nxt.tx_st = TX_DATA;
          s_nxt.tx_bit = 4'h0;
        end
      end
      TX_DATA: begin
        if (tx_last) begin
          s_nxt.tx_sh = s_r.tx_sh >> 1;
          s_nxt.tx_bit = s_r.tx_bit + 4'h1;
          if (s_r.tx_bit == nbits - 4'h1) begin
            s_nxt.tx_st = s_r.line_format_control[LCR_PEN] ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR: begin
        if (tx_last) begin
          s_nxt.tx_st = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_last) begin
          s_nxt.tx_st = TX_IDLE;
        end
      end
      default: s_nxt.tx_st = TX_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Receiver, sampling mid-bit on the 16x tick
    rx_data = s_r.rx_sh >> (WL_MAX - nbits);
    if (tick) begin
      case (s_r.rx_st)
        RX_IDLE: begin
          if (!lin) begin
            s_nxt.rx_st = RX_START;
            s_nxt.rx_smp = 6'h00;
          end
        end
        RX_START: begin
          s_nxt.rx_smp = s_r.rx_smp + 6'h01;
          if (s_r.rx_smp == HALF_LAST) begin
            rx_sample = 1'b1;
            s_nxt.rx_smp = 6'h00;
            s_nxt.rx_bit = 4'h0;
            s_nxt.rx_zero = 1'b1;
            s_nxt.rx_st = lin ? RX_IDLE : RX_DATA; // Glitch, not a start bit
          end
        end
        RX_DATA, RX_PAR, RX_STOP: begin
          s_nxt.rx_smp = s_r.rx_smp + 6'h01;
          if (s_r.rx_smp == OVS_LAST) begin
            rx_sample = 1'b1;
            s_nxt.rx_smp = 6'h00;
            s_nxt.rx_zero = s_r.rx_zero & ~lin;
            if (s_r.rx_st == RX_DATA) begin
              s_nxt.rx_sh = {lin, s_r.rx_sh[7:1]};
              s_nxt.rx_bit = s_r.rx_bit + 4'h1;
              if (s_r.rx_bit == nbits - 4'h1) begin
                s_nxt.rx_st = s_r.line_format_control[LCR_PEN] ? RX_PAR : RX_STOP;
              end
            end else if (s_r.rx_st == RX_PAR) begin
              s_nxt.rx_pe = lin != par_bit(s_r.line_format_control, rx_data);
              s_nxt.rx_st = RX_STOP;
            end else begin
              ent.data = rx_data;
              ent.pe = s_r.line_format_control[LCR_PEN] & s_r.rx_pe;
              ent.fe = ~lin;
              ent.brk = s_r.rx_zero & ~lin;
              s_nxt.rx_st = ent.brk ? RX_BRKW : RX_IDLE;
              s_nxt.rx_pe = 1'b0;
              if (enh && s_r.modem_output_control[MCR_XANY] && i_tx_halted) begin
                s_nxt.xon_resume = 1'b1;
              end
              if (s_r.rx_cnt == FULL) begin
                s_nxt.overrun = 1'b1;
                ovr_evt = 1'b1;
                s_nxt.ls_pend = 1'b1;
              end else if (!(i_sw_flow_on && (rx_data == i_xon_char || rx_data == i_xoff_char))) begin
                rx_push = 1'b1;
                push_tag = ent.pe | ent.fe | ent.brk;
              end
            end
          end
        end
        RX_BRKW: begin
          if (lin) begin
            s_nxt.rx_st = RX_IDLE;
          end
        end
        default: s_nxt.rx_st = RX_IDLE;
      endcase
    end
    // Short infrared pulses are held until the next sample point
    s_nxt.ir_hit = ir_pulse | (s_r.ir_hit & ~rx_sample);

    ////////////////////////////////////////////////////////////////////////
    // APB read value and address decode
    bad_addr = 1'b0;
    rd_val = 8'h00;
    case (i_paddr)
      ADDR_DATA: rd_val = dlab ? s_r.div[7:0] : head.data;
      ADDR_DIVH: begin
        rd_val = s_r.div[15:8];
        bad_addr = ~dlab;
      end
      ADDR_LCR: rd_val = s_r.line_format_control;
      ADDR_MCR: rd_val = s_r.modem_output_control;
      ADDR_EFR: rd_val = s_r.enhanced_feature_control;
      ADDR_LSR: begin
        rd_val[0] = s_r.rx_cnt != '0;
        rd_val[1] = s_r.overrun;
        rd_val[2] = (s_r.rx_cnt != '0) & ~s_r.tags_hidden & head.pe;
        rd_val[3] = (s_r.rx_cnt != '0) & ~s_r.tags_hidden & head.fe;
        rd_val[4] = (s_r.rx_cnt != '0) & ~s_r.tags_hidden & head.brk;
        rd_val[5] = s_r.tx_cnt == '0;
        rd_val[6] = (s_r.tx_cnt == '0) & (s_r.tx_st == TX_IDLE);
        rd_val[7] = s_r.err_cnt != '0;
      end
      default: bad_addr = 1'b1;
    endcase

    // Answer one cycle into the access phase, act when it completes
    if (acc && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = bad_addr;
      s_nxt.prdata = (bad_addr || i_pwrite) ? 32'h0000_0000 : {24'h000000, rd_val};
    end else begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
    end
    if (done && !bad_addr) begin
      if (i_pwrite) begin
        case (i_paddr)
          ADDR_DATA: begin
            if (dlab) begin
              s_nxt.div[7:0] = i_pwdata[7:0];
            end else if (s_r.tx_cnt != FULL) begin
              tx_push = 1'b1; // Writes to a full FIFO are dropped
            end
          end
          ADDR_DIVH: s_nxt.div[15:8] = i_pwdata[7:0];
          ADDR_LCR: s_nxt.line_format_control = i_pwdata[7:0];
          ADDR_MCR: begin
            s_nxt.modem_output_control = (i_pwdata[7:0] & ~MCR_ENH_MASK) | (s_r.modem_output_control & MCR_ENH_MASK);
            if (enh) begin
              s_nxt.modem_output_control = i_pwdata[7:0];
            end
          end
          ADDR_EFR: s_nxt.enhanced_feature_control = i_pwdata[7:0];
          default: ;
        endcase
      end else if (i_paddr == ADDR_DATA && !dlab && s_r.rx_cnt != '0) begin
        rx_pop = 1'b1;
      end else if (i_paddr == ADDR_LSR) begin
        lsr_rd = 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // FIFO bookkeeping and sticky flags; a new event wins over the clear
    if (tx_push) begin
      s_nxt.txf[s_r.tx_wp] = i_pwdata[7:0];
      s_nxt.tx_wp = s_r.tx_wp + AW'(1);
    end
    if (tx_pop) begin
      s_nxt.tx_rp = s_r.tx_rp + AW'(1);
    end
    s_nxt.tx_cnt = s_r.tx_cnt + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
    if (rx_push) begin
      s_nxt.rxf[s_r.rx_wp] = ent;
      s_nxt.rx_wp = s_r.rx_wp + AW'(1);
    end
    if (rx_pop) begin
      s_nxt.rx_rp = s_r.rx_rp + AW'(1);
      s_nxt.tags_hidden = 1'b0;
    end
    s_nxt.rx_cnt = s_r.rx_cnt + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
    s_nxt.err_cnt = s_r.err_cnt + (AW + 1)'(push_tag) - (AW + 1)'(rx_pop & pop_tag);
    if (lsr_rd) begin
      s_nxt.overrun = ovr_evt;
      s_nxt.ls_pend = 1'b0;
      // An empty store has no head yet; the next arrival must show its own tags
      s_nxt.tags_hidden = s_r.rx_cnt != '0;
    end
    if (ovr_evt) begin
      s_nxt.ls_pend = 1'b1;
    end
    if (push_tag) begin
      s_nxt.ls_pend = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins; loopback parks the line, DTR and RTS at their idle level
    if (loop) begin
      s_nxt.tx_pin = ~ir_on;
    end else if (ir_on) begin
      s_nxt.tx_pin = ~ser & (s_r.tx_smp < IR_PULSE) & ~s_r.line_format_control[LCR_BRK];
    end else begin
      s_nxt.tx_pin = ser;
    end
    s_nxt.dtr_n = loop | ~s_r.modem_output_control[MCR_DTR];
    if (s_r.enhanced_feature_control[EFR_ARTS]) begin
      s_nxt.rts_n = loop | (s_r.rx_cnt >= RTS_HI);
    end else begin
      s_nxt.rts_n = loop | ~s_r.modem_output_control[MCR_RTS];
    end
    s_nxt.op2_n = ~s_r.modem_output_control[MCR_OP2];
    s_nxt.irq_oe = s_r.modem_output_control[MCR_OP2];
    s_nxt.loop_ring = loop & s_r.modem_output_control[MCR_OP1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.line_format_control <= LCR_RST;
      s_r.modem_output_control <= MCR_RST;
      s_r.enhanced_feature_control <= EFR_RST;
      s_r.div <= DIV_RST;
      s_r.tx_st <= TX_IDLE;
      s_r.rx_st <= RX_IDLE;
      s_r.tx_pin <= 1'b1;
      s_r.dtr_n <= 1'b1;
      s_r.rts_n <= 1'b1;
      s_r.op2_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_prdata = s_r.prdata;
  assign o_pready = s_r.pready;
  assign o_pslverr = s_r.pslverr;
  assign o_tx = s_r.tx_pin;
  assign o_dtr_n = s_r.dtr_n;
  assign o_rts_n = s_r.rts_n;
  assign o_user_output_2_n = s_r.op2_n;
  assign o_irq = s_r.ls_pend;
  assign o_irq_oe = s_r.irq_oe;
  assign o_loop_ring = s_r.loop_ring;
  assign o_xon_resume = s_r.xon_resume;
endmodule
`default_nettype wire

//--- pkg/ulm_pkg.sv
// Constants, field positions and shared types of the UART line/modem control block
package ulm_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_DIVH = 8'h04;
  localparam logic [7:0] ADDR_LCR = 8'h0C;
  localparam logic [7:0] ADDR_MCR = 8'h10;
  localparam logic [7:0] ADDR_LSR = 8'h14;
  localparam logic [7:0] ADDR_EFR = 8'h20;
  // Line format fields
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EVEN = 4;
  localparam int LCR_FORCE = 5;
  localparam int LCR_BRK = 6;
  localparam int LCR_DLAB = 7;
  // Modem output control fields
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OP1 = 2;
  localparam int MCR_OP2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_XANY = 5;
  localparam int MCR_IR = 6;
  localparam int MCR_PRE = 7;
  localparam logic [7:0] MCR_ENH_MASK = 8'hE0;
  // Enhanced feature fields
  localparam int EFR_ENH = 4;
  localparam int EFR_ARTS = 6;
  // Reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  // Timing in 16x sample ticks, prescaler count in clocks, word lengths in bits
  localparam logic [5:0] OVS_LAST = 6'h0F;
  localparam logic [5:0] HALF_LAST = 6'h07;
  localparam logic [5:0] STOP15_LAST = 6'h17;
  localparam logic [5:0] STOP2_LAST = 6'h1F;
  localparam logic [5:0] IR_PULSE = 6'h03;
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam logic [3:0] WL_BASE = 4'h5;
  localparam logic [3:0] WL_MAX = 4'h8;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulm_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRKW} ulm_rx_state_type;
  // One stored receive character with its error tags
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ulm_rx_entry_type;
endpackage

//--- tb/ulm_top_props.sv
// Concurrent checks on the ports of the line and modem control block
`timescale 1ns/1ps
`default_nettype none
module ulm_top_props
  import ulm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_tx,
  input wire logic o_dtr_n,
  input wire logic o_rts_n,
  input wire logic o_user_output_2_n,
  input wire logic o_irq_oe,
  input wire logic o_loop_ring,
  input wire logic o_xon_resume
);
  logic wr_done;
  logic wr_mcr;
  logic [7:0] mcr_r;
  logic [7:0] lcr_r;
  logic arts_r;
  // Shadow of the written control bits, taken at the completing edge
  assign wr_done = i_psel && i_penable && o_pready && i_pwrite;
  assign wr_mcr = wr_done && i_paddr == ADDR_MCR;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mcr_r <= 8'h00;
      lcr_r <= 8'h00;
      arts_r <= 1'b0;
    end else begin
      if (wr_mcr) mcr_r <= i_pwdata[7:0];
      if (wr_done && i_paddr == ADDR_LCR) lcr_r <= i_pwdata[7:0];
      if (wr_done && i_paddr == ADDR_EFR) arts_r <= i_pwdata[EFR_ARTS];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("pready late");
  a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready held");
  a_err_unmapped:
    assert property (i_psel && i_penable && o_pready && i_paddr == ADDR_DIVH && !lcr_r[LCR_DLAB] |-> o_pslverr)
    else $error("divisor high reachable");
  a_read_upper: assert property (o_pready |-> o_prdata[31:8] == 24'h000000) else $error("upper bits set");
  a_dtr_level:
    assert property (wr_mcr |=> ##1 o_dtr_n == !(mcr_r[MCR_DTR] && !mcr_r[MCR_LOOP])) else $error("dtr level");
  a_rts_level:
    assert property (wr_mcr && !arts_r |=> ##1 o_rts_n == !(mcr_r[MCR_RTS] && !mcr_r[MCR_LOOP])) else $error("rts level");
  a_user2_oe:
    assert property (wr_mcr |=> ##1 (o_user_output_2_n == !mcr_r[MCR_OP2] && o_irq_oe == mcr_r[MCR_OP2]))
    else $error("output two");
  a_ring_loop:
    assert property (wr_mcr |=> ##1 o_loop_ring == (mcr_r[MCR_LOOP] && mcr_r[MCR_OP1])) else $error("ring loop");
  a_break_low: assert property ((lcr_r[LCR_BRK] && !mcr_r[MCR_LOOP]) [*3] |-> !o_tx) else $error("break released");
  a_resume_pulse: assert property (o_xon_resume |=> !o_xon_resume) else $error("resume held");
endmodule
bind ulm_top ulm_top_props ulm_top_props_inst (.*);
`default_nettype wire

//--- tb/ulm_remote_model.sv
// Remote serial transmitter driving the block's receive line
`timescale 1ns/1ps
`default_nettype none
module ulm_remote_model (
  input wire logic i_clk,
  output logic o_line
);
  // Line rests at mark between frames
  initial o_line = 1'b1;
  // Level for a number of 16-clock bit cells (divisor one)
  task automatic put(input logic b, input int cells);
    o_line <= b;
    repeat (16 * cells) @(posedge i_clk);
  endtask
  // Start low, data LSB first, optional parity, stop level sb, then idle
  task automatic send(input logic [7:0] d, input int n, input logic pen, input logic pb, input logic sb);
    @(posedge i_clk);
    put(1'b0, 1);
    for (int k = 0; k < n; k++) put(d[k], 1);
    if (pen) put(pb, 1);
    put(sb, 1);
    put(1'b1, 1);
  endtask
  // Infrared 8N1 frame, idle high: a zero bit is a short low pulse at the start of its cell
  task automatic send_ir(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    @(posedge i_clk);
    for (int k = 0; k < 10; k++) begin
      o_line <= f[k];
      repeat (3) @(posedge i_clk);
      o_line <= 1'b1;
      repeat (13) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/test_uart_line_modem_control.sv
// Register-level bench of the line and modem control block
`timescale 1ns/1ps
`default_nettype none
module test_uart_line_modem_control;
  import ulm_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_psel, i_penable, i_pwrite, i_tx_halted, i_sw_flow_on, i_rx;
  logic [7:0] i_paddr, i_xon_char, i_xoff_char;
  logic [31:0] i_pwdata, o_prdata;
  logic o_pready, o_pslverr, o_tx, o_dtr_n, o_rts_n, o_user_output_2_n;
  logic o_irq, o_irq_oe, o_loop_ring, o_xon_resume;
  int n_fail = 0;
  int cmp_count = 0;
  int n_res = 0;
  always #2 i_clk = ~i_clk;
  ulm_top #(.DEPTH(16), .RTS_LVL(14)) ulm_top_inst (.*);
  ulm_remote_model ulm_remote_model_inst (.i_clk(i_clk), .o_line(i_rx));
  // Resume pulses are counted as they appear
  always @(posedge i_clk) if (o_xon_resume === 1'b1) n_res++;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r, output logic e);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h000000, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r[7:0], x);
  endtask
  // Two characters back to back; first frame sampled at mid-bit
  task automatic tx_frame(input logic [7:0] line_format_control);
    int n, t, stp;
    logic [7:0] got, dm;
    logic p;
    n = line_format_control[1:0] + 5;
    dm = 8'hA5 & (8'hFF >> (8 - n));
    p = line_format_control[5] ? !line_format_control[4] : (line_format_control[4] ? ^dm : !(^dm));
    stp = line_format_control[2] ? ((n == 5) ? 24 : 32) : 16;
    got = 8'h00;
    wr(ADDR_LCR, line_format_control);
    fork
      begin
        wr(ADDR_DATA, 8'hA5);
        wr(ADDR_DATA, 8'hA5);
      end
      begin
        t = 0;
        while (o_tx !== 1'b0 && t < 100) begin
          @(posedge i_clk);
          t++;
        end
        repeat (7) @(posedge i_clk);
        for (int k = 0; k < n; k++) begin
          repeat (16) @(posedge i_clk);
          got[k] = o_tx;
        end
        chk(got, dm);
        if (line_format_control[3]) begin
          repeat (16) @(posedge i_clk);
          chk(8'(o_tx), 8'(p));
        end
        repeat (16) @(posedge i_clk);
        chk(8'(o_tx), 8'h01);
        t = 16;
        do begin
          @(posedge i_clk);
          t++;
        end while (o_tx !== 1'b0 && t < 80);
        chk(8'(t >= stp + 7 && t <= stp + 11), 8'h01);
      end
    join
    rd(ADDR_LSR, 8'h20);
    repeat (208) @(posedge i_clk);
    rd(ADDR_LSR, 8'h60);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] fmt [7];
    fmt = '{8'h00, 8'h04, 8'h05, 8'h0A, 8'h1F, 8'h2B, 8'h3B};
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h00000000;
    i_tx_halted = 1'b0;
    i_sw_flow_on = 1'b0;
    i_xon_char = 8'h11;
    i_xoff_char = 8'h13;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(ADDR_LSR, 8'h60);
    rd(ADDR_LCR, 8'h00);
    rd(ADDR_MCR, 8'h00);
    // Native bus mode only, so the output-2 bit may be set
    for (int v = 0; v < 16; v++) begin
      wr(ADDR_MCR, 8'(v));
      repeat (2) @(posedge i_clk);
      chk({4'h0, o_dtr_n, o_rts_n, o_user_output_2_n, o_irq_oe}, {4'h0, !v[0], !v[1], !v[3], v[3]});
    end
    // Enhanced bits are latched unless enhanced access is on
    wr(ADDR_MCR, 8'hE0);
    rd(ADDR_MCR, 8'h00);
    wr(ADDR_EFR, 8'h10);
    wr(ADDR_MCR, 8'hE0);
    wr(ADDR_EFR, 8'h00);
    wr(ADDR_MCR, 8'h00);
    rd(ADDR_MCR, 8'hE0);
    wr(ADDR_EFR, 8'h10);
    wr(ADDR_MCR, 8'h00);
    apb(1'b0, ADDR_DIVH, 8'h00, r, e);
    chk(8'(e), 8'h01);
    wr(ADDR_LCR, 8'h80);
    wr(ADDR_DIVH, 8'h00);
    wr(ADDR_DATA, 8'h01);
    rd(ADDR_DATA, 8'h01);
    foreach (fmt[i]) tx_frame(fmt[i]);
    wr(ADDR_LCR, 8'h43);
    repeat (20) @(posedge i_clk);
    chk(8'(o_tx), 8'h00);
    wr(ADDR_LCR, 8'h03);
    repeat (2) @(posedge i_clk);
    chk(8'(o_tx), 8'h01);
    // Wrong parity, then a missing stop bit
    wr(ADDR_LCR, 8'h0B);
    ulm_remote_model_inst.send(8'h3C, 8, 1'b1, 1'b0, 1'b1);
    ulm_remote_model_inst.send(8'h81, 8, 1'b1, 1'b1, 1'b0);
    repeat (4) @(posedge i_clk);
    chk(8'(o_irq), 8'h01);
    rd(ADDR_LSR, 8'hE5);
    repeat (2) @(posedge i_clk);
    chk(8'(o_irq), 8'h00);
    rd(ADDR_LSR, 8'hE1);
    rd(ADDR_DATA, 8'h3C);
    rd(ADDR_LSR, 8'hE9);
    rd(ADDR_DATA, 8'h81);
    rd(ADDR_LSR, 8'h60);
    // Break with parity on: the all-zero parity slot is wrong for odd parity, so that tag is set too
    ulm_remote_model_inst.put(1'b0, 14);
    ulm_remote_model_inst.put(1'b1, 2);
    rd(ADDR_LSR, 8'hFD);
    rd(ADDR_DATA, 8'h00);
    rd(ADDR_LSR, 8'h60);
    // Seventeen characters into a sixteen-deep store, auto RTS on
    wr(ADDR_LCR, 8'h03);
    wr(ADDR_EFR, 8'h50);
    wr(ADDR_MCR, 8'h02);
    for (int k = 0; k < 17; k++) ulm_remote_model_inst.send(8'(k), 8, 1'b0, 1'b0, 1'b1);
    chk(8'(o_rts_n), 8'h01);
    rd(ADDR_LSR, 8'h63);
    rd(ADDR_LSR, 8'h61);
    for (int k = 0; k < 16; k++) rd(ADDR_DATA, 8'(k));
    chk(8'(o_rts_n), 8'h00);
    rd(ADDR_LSR, 8'h60);
    wr(ADDR_MCR, 8'h15);
    repeat (2) @(posedge i_clk);
    chk({6'h00, o_loop_ring, o_dtr_n}, 8'h03);
    wr(ADDR_DATA, 8'h96);
    repeat (40) @(posedge i_clk);
    chk(8'(o_tx), 8'h01);
    repeat (160) @(posedge i_clk);
    rd(ADDR_DATA, 8'h96);
    // Prescaler on: the same loopback frame takes four times as long
    wr(ADDR_MCR, 8'h90);
    wr(ADDR_DATA, 8'h69);
    repeat (300) @(posedge i_clk);
    rd(ADDR_LSR, 8'h20);
    repeat (500) @(posedge i_clk);
    rd(ADDR_LSR, 8'h61);
    rd(ADDR_DATA, 8'h69);
    wr(ADDR_MCR, 8'h20);
    i_tx_halted <= 1'b1;
    i_sw_flow_on <= 1'b1;
    ulm_remote_model_inst.send(8'h41, 8, 1'b0, 1'b0, 1'b1);
    chk(8'(n_res), 8'h01);
    ulm_remote_model_inst.send(8'h13, 8, 1'b0, 1'b0, 1'b1);
    rd(ADDR_LSR, 8'h61);
    rd(ADDR_DATA, 8'h41);
    // Infrared with idle-high receive polarity; transmit pin idles low
    wr(ADDR_MCR, 8'h44);
    repeat (2) @(posedge i_clk);
    chk(8'(o_tx), 8'h00);
    ulm_remote_model_inst.send_ir(8'h5A);
    rd(ADDR_DATA, 8'h5A);
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge i_clk);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
